/* File: bench/port_pin_function_mux_tb.sv */
// Self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps
module port_pin_function_mux_tb;
   logic        aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, irq, wake_req;
   logic        ext_irq_line_zero, ext_irq_line_one;
   logic        timer_b_pwm_out = 1'b0, timer_c_pwm_out = 1'b0;
   logic        cmp_result_pin = 1'b0, external_reset_n = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [7:0]  pa_pin_i, pb_pin_i, d, e, ext_a = 8'h00, ext_b = 8'h00;
   ppfm_pkg::ppfm_pad_t pa_pad, pb_pad;
   int          failures = 0, checked = 0;
   logic [31:0] n0 = '0, n1 = '0, nw = '0, k0, k1;

   ppfm_top i_dut (.*);
   ppfm_board i_bda (.pad(pa_pad), .ext(ext_a), .pin(pa_pin_i));
   ppfm_board i_bdb (.pad(pb_pad), .ext(ext_b), .pin(pb_pin_i));

   always #20 aclk = ~aclk;
   // Pulse counters for the event outputs
   // Unknown pulses stay visible; counting starts once reset is released
   always @(posedge aclk) begin
      if (aresetn) begin
         n0 <= n0 + ext_irq_line_zero;
         n1 <= n1 + ext_irq_line_one;
         nw <= nw + wake_req;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v,
                     input logic [1:0] er);
      logic aw, w, b;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(negedge aclk);
         aw = s_axi_awready;
         w  = s_axi_wready;
         b  = s_axi_bvalid;
         if (b) chk(s_axi_bresp, er);
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end while (!b);
      // Let an edge pass so the next call never re-drives bready at once
      @(posedge aclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ex,
                     input logic [31:0] m, input logic [1:0] er);
      logic ar, r;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(negedge aclk);
         ar = s_axi_arready;
         r  = s_axi_rvalid;
         if (r) chk(s_axi_rdata & m, ex);
         if (r) chk(s_axi_rresp, er);
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (r) s_axi_rready <= 1'b0;
      end while (!r);
      @(posedge aclk);
   endtask

   task automatic tally_and_finish();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #400000;
      failures++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(87));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(ppfm_pkg::ADDR_PA_DIE, 32'hFF, 32'hFF, ppfm_pkg::RESP_OKAY);
      rd(12'h0FC, 32'h0, 32'h0, ppfm_pkg::RESP_SLVERR);
      wr(ppfm_pkg::ADDR_PA_IN, 32'h1, ppfm_pkg::RESP_SLVERR);
      $display("test reset done");
      d = 8'($urandom);
      e = 8'($urandom);
      ext_b <= e;
      wr(ppfm_pkg::ADDR_PA_DIR, 32'hFF, ppfm_pkg::RESP_OKAY);
      wr(ppfm_pkg::ADDR_PA_DATA, {24'h0, d}, ppfm_pkg::RESP_OKAY);
      wr(ppfm_pkg::ADDR_PB_PH, 32'h0F, ppfm_pkg::RESP_OKAY);
      wr(ppfm_pkg::ADDR_PB_PL, 32'h10, ppfm_pkg::RESP_OKAY);
      repeat (8) @(posedge aclk);
      chk(pa_pad.o, d);
      chk(pa_pad.oe, 8'hFF);
      chk(pb_pad.oe, 8'h00);
      rd(ppfm_pkg::ADDR_PA_IN, d, 32'hFF, ppfm_pkg::RESP_OKAY);
      rd(ppfm_pkg::ADDR_PB_IN, {e[7:5], 5'h0F}, 32'hFF, 2'b00);
      wr(ppfm_pkg::ADDR_PB_DIE, 32'h0, ppfm_pkg::RESP_OKAY);
      wr(ppfm_pkg::ADDR_PA_DIE, 32'h0, ppfm_pkg::RESP_OKAY);
      rd(ppfm_pkg::ADDR_PB_IN, 32'h0, 32'hFF, ppfm_pkg::RESP_OKAY);
      rd(ppfm_pkg::ADDR_PA_IN, 32'h0, 32'hFF, ppfm_pkg::RESP_OKAY);
      $display("test pins done");
      wr(ppfm_pkg::ADDR_ALT, 32'h1F8, ppfm_pkg::RESP_OKAY);
      for (int v = 0; v < 2; v++) begin
         timer_b_pwm_out <= v[0];
         timer_c_pwm_out <= ~v[0];
         cmp_result_pin  <= v[0];
         @(negedge aclk);
         chk(pa_pad.o, {d[7:4], v[0], d[2:1], v[0]});
         chk(pb_pad.o[7:4], {{3{~v[0]}}, v[0]});
         chk(pb_pad.oe, 8'hF0);
         @(posedge aclk);
      end
      $display("test alternate outputs done");
      wr(ppfm_pkg::ADDR_ALT, 32'h0, ppfm_pkg::RESP_OKAY);
      wr(ppfm_pkg::ADDR_PA_DIR, 32'h0, ppfm_pkg::RESP_OKAY);
      wr(ppfm_pkg::ADDR_PA_DIE, 32'hFF, ppfm_pkg::RESP_OKAY);
      wr(ppfm_pkg::ADDR_PB_DIE, 32'hFF, ppfm_pkg::RESP_OKAY);
      wr(ppfm_pkg::ADDR_IRQ_MASK, 32'h7, ppfm_pkg::RESP_OKAY);
      for (int f = 0; f < 2; f++) begin
         wr(ppfm_pkg::ADDR_ALT, 32'(f * 6), ppfm_pkg::RESP_OKAY);
         repeat (8) @(posedge aclk);
         rd(ppfm_pkg::ADDR_IRQ_STAT, 32'h0, 32'h0, ppfm_pkg::RESP_OKAY);
         k0 = n0;
         k1 = n1;
         ext_a <= 8'h11;
         repeat (8) @(posedge aclk);
         chk(n0 - k0, 1 - f);
         chk(n1 - k1, 1 - f);
         ext_a <= 8'h00;
         repeat (8) @(posedge aclk);
         chk(n0 - k0, 1);
         chk(n1 - k1, 1);
         chk(irq, 1'b1);
         rd(ppfm_pkg::ADDR_IRQ_STAT, 32'h7, 32'h7, ppfm_pkg::RESP_OKAY);
         @(negedge aclk);
         chk(irq, 1'b0);
         @(posedge aclk);
      end
      // Port B bit 5 starts low so the source switch itself makes no edge
      ext_b <= e & 8'hDF;
      wr(ppfm_pkg::ADDR_IRQ_MASK, 32'h2, ppfm_pkg::RESP_OKAY);
      wr(ppfm_pkg::ADDR_ALT, 32'h1, ppfm_pkg::RESP_OKAY);
      k0 = n0;
      ext_a <= 8'h01;
      repeat (8) @(posedge aclk);
      chk(n0 - k0, 0);
      ext_b <= e | 8'h20;
      repeat (8) @(posedge aclk);
      chk(n0 - k0, 1);
      chk(irq, 1'b0);
      rd(ppfm_pkg::ADDR_IRQ_STAT, 32'h5, 32'h7, ppfm_pkg::RESP_OKAY);
      $display("test interrupts done");
      k0 = nw;
      external_reset_n <= 1'b0;
      repeat (8) @(posedge aclk);
      chk(int'(nw != k0), 1);
      external_reset_n <= 1'b1;
      wr(ppfm_pkg::ADDR_PA_DIE, 32'h0, ppfm_pkg::RESP_OKAY);
      repeat (8) @(posedge aclk);
      k0 = nw;
      external_reset_n <= 1'b0;
      ext_a <= 8'hFE;
      repeat (8) @(posedge aclk);
      chk(nw - k0, 0);
      external_reset_n <= 1'b1;
      $display("test wake done");
      tally_and_finish();
   end
endmodule

/* File: bench/ppfm_board.sv */
// Board model: resolves pad drive, pulls and external levels on the pins
`timescale 1ns/1ps
module ppfm_board (
   input  wire ppfm_pkg::ppfm_pad_t pad,
   input  wire logic [7:0]          ext,
   output logic      [7:0]          pin
);
   // Driven pad wins, then pull-low, then pull-high, else the board level
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad.oe[i])
            pin[i] = pad.o[i];
         else if (pad.pull_lo[i])
            pin[i] = 1'b0;
         else
            pin[i] = pad.pull_hi[i] ? 1'b1 : ext[i];
      end
   end
endmodule

/* File: rtl/ppfm_pad.sv */
// One port of eight pads: output mux with alternate priority, input gating
`timescale 1ns/1ps
module ppfm_pad (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire ppfm_pkg::ppfm_port_cfg_t cfg,
   input  wire logic [7:0]              alt_en,
   input  wire logic [7:0]              alt_val,
   input  wire logic [7:0]              pin_i,
   output ppfm_pkg::ppfm_pad_t          pad,
   output logic      [7:0]              din,
   output logic      [7:0]              toggle
);
   logic [7:0] sync_w;
   logic [7:0] gated_w;
   logic [7:0] prev_reg;

   ppfm_sync #(.W(8)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (pin_i),
      .dout    (sync_w)
   );

   // Disabled digital inputs read low and cannot toggle
   assign gated_w = sync_w & cfg.die;
   assign din     = gated_w;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_reg <= ppfm_pkg::ZERO8;
      end else begin
         prev_reg <= gated_w;
      end
   end

   assign toggle = (gated_w ^ prev_reg) & cfg.die;

   always_comb begin
      pad.pull_hi = cfg.pull_hi & ~cfg.pull_lo;
      pad.pull_lo = cfg.pull_lo;
      pad.oe      = cfg.dir | alt_en;
      pad.o       = (alt_en & alt_val) | (~alt_en & cfg.data);
   end
endmodule

/* File: rtl/ppfm_pkg.sv */
// Package for the port pin function multiplexer: register map and carriers
package ppfm_pkg;
   localparam int unsigned PORT_W = 8;
   localparam logic [11:0] ADDR_PA_DATA  = 12'h000;
   localparam logic [11:0] ADDR_PA_DIR   = 12'h004;
   localparam logic [11:0] ADDR_PA_PH    = 12'h008;
   localparam logic [11:0] ADDR_PA_PL    = 12'h00C;
   localparam logic [11:0] ADDR_PA_DIE   = 12'h010;
   localparam logic [11:0] ADDR_PA_IN    = 12'h014;
   localparam logic [11:0] ADDR_PB_DATA  = 12'h020;
   localparam logic [11:0] ADDR_PB_DIR   = 12'h024;
   localparam logic [11:0] ADDR_PB_PH    = 12'h028;
   localparam logic [11:0] ADDR_PB_PL    = 12'h02C;
   localparam logic [11:0] ADDR_PB_DIE   = 12'h030;
   localparam logic [11:0] ADDR_PB_IN    = 12'h034;
   localparam logic [11:0] ADDR_ALT      = 12'h040;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h044;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h048;
   localparam logic [7:0]  DIE_RESET     = 8'hFF;
   localparam logic [7:0]  ZERO8         = 8'h00;
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;
   // Alternate function control bit positions
   localparam int unsigned ALT_EXT0_SEL  = 0;
   localparam int unsigned ALT_EXT0_FALL = 1;
   localparam int unsigned ALT_EXT1_FALL = 2;
   localparam int unsigned ALT_TB_PA3    = 3;
   localparam int unsigned ALT_TB_PB4    = 4;
   localparam int unsigned ALT_TC_PB5    = 5;
   localparam int unsigned ALT_TC_PB6    = 6;
   localparam int unsigned ALT_TC_PB7    = 7;
   localparam int unsigned ALT_CMP_PA0   = 8;
   localparam int unsigned ALT_W         = 9;
   // Status bit positions
   localparam int unsigned ST_EXT0 = 0;
   localparam int unsigned ST_EXT1 = 1;
   localparam int unsigned ST_WAKE = 2;
   localparam int unsigned ST_W    = 3;
   // Pin indices
   localparam int unsigned PIN_EXT0_A = 0;
   localparam int unsigned PIN_EXT1_A = 4;
   localparam int unsigned PIN_RST_A  = 5;
   localparam int unsigned PIN_EXT0_B = 5;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
      logic [7:0] pull_hi;
      logic [7:0] pull_lo;
      logic [7:0] die;
   } ppfm_port_cfg_t;

   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
      logic [7:0] pull_hi;
      logic [7:0] pull_lo;
   } ppfm_pad_t;
endpackage

/* File: rtl/ppfm_sync.sv */
// Three-stage input synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module ppfm_sync #(
   parameter int unsigned W = 8
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   initial begin
      if (W < 1) $error("ppfm_sync width must be at least one");
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change counts once the second and third stages agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dout <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               dout[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule

/* File: rtl/ppfm_top.sv */
// Port A/B pin function multiplexer with AXI4-Lite register access
// Overview of operation
// - Each pin is input or output, with pull-high or pull-low chosen.
// - Port A input-enable bit zero blocks input and pin wake-up.
// - Port B input-enable bit zero blocks input and pin wake-up.
// - Port A bit 5 reset pin wakes system unless its enable is zero.
// - External interrupts fire on rising or falling edge, register chosen.
// - Interrupt line zero comes from port A bit 0 or B bit 5.
// - Interrupt line one comes from edges on port A bit 4.
// - Second timer PWM may drive port A bit 3 or B bit 4.
// - Third timer PWM may drive port B bits 5, 6 or 7.
// - Comparator result may drive port A bit 0.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module ppfm_top (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [11:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [11:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic [7:0]          pa_pin_i,
   input  wire logic [7:0]          pb_pin_i,
   output ppfm_pkg::ppfm_pad_t      pa_pad,
   output ppfm_pkg::ppfm_pad_t      pb_pad,
   input  wire logic                timer_b_pwm_out,
   input  wire logic                timer_c_pwm_out,
   input  wire logic                cmp_result_pin,
   input  wire logic                external_reset_n,
   output logic                     ext_irq_line_zero,
   output logic                     ext_irq_line_one,
   output logic                     wake_req,
   output logic                     irq
);
   ppfm_pkg::ppfm_port_cfg_t pa_cfg_reg;
   ppfm_pkg::ppfm_port_cfg_t pb_cfg_reg;
   logic [ppfm_pkg::ALT_W-1:0] alt_reg;
   logic [ppfm_pkg::ST_W-1:0]  stat_reg;
   logic [ppfm_pkg::ST_W-1:0]  mask_reg;
   logic [ppfm_pkg::ST_W-1:0]  ev_w;
   logic [7:0] pa_alt_en;
   logic [7:0] pa_alt_val;
   logic [7:0] pb_alt_en;
   logic [7:0] pb_alt_val;
   logic [7:0] pa_din;
   logic [7:0] pb_din;
   logic [7:0] pa_tog;
   logic [7:0] pb_tog;
   logic [2:0] rst_sync_reg;
   logic       rst_pin_prev_reg;
   logic       rst_wake_w;
   logic       e0_src_w;
   logic       e0_prev_reg;
   logic       e1_prev_reg;
   logic       e0_hit_w;
   logic       e1_hit_w;
   logic       aw_have_reg;
   logic       w_have_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic       wr_do;
   logic       rd_do;
   logic       rd_stat;

   // Edge select: fall_sel high picks a falling edge, else a rising edge
   function automatic logic edge_hit(input logic cur, input logic prev,
                                     input logic fall_sel);
      edge_hit = fall_sel ? (prev & ~cur) : (cur & ~prev);
   endfunction

   // Byte-lane write merge for an eight-bit register
   function automatic logic [7:0] lane0(input logic [7:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
      lane0 = s[0] ? d[7:0] : old;
   endfunction

   // ---------------- Alternate output routing
   always_comb begin
      pa_alt_en  = ppfm_pkg::ZERO8;
      pa_alt_val = ppfm_pkg::ZERO8;
      pb_alt_en  = ppfm_pkg::ZERO8;
      pb_alt_val = ppfm_pkg::ZERO8;
      pa_alt_en[0]  = alt_reg[ppfm_pkg::ALT_CMP_PA0];
      pa_alt_val[0] = cmp_result_pin;
      pa_alt_en[3]  = alt_reg[ppfm_pkg::ALT_TB_PA3];
      pa_alt_val[3] = timer_b_pwm_out;
      pb_alt_en[4]  = alt_reg[ppfm_pkg::ALT_TB_PB4];
      pb_alt_val[4] = timer_b_pwm_out;
      pb_alt_en[5]  = alt_reg[ppfm_pkg::ALT_TC_PB5];
      pb_alt_en[6]  = alt_reg[ppfm_pkg::ALT_TC_PB6];
      pb_alt_en[7]  = alt_reg[ppfm_pkg::ALT_TC_PB7];
      pb_alt_val[7:5] = {3{timer_c_pwm_out}};
   end

   ppfm_pad u_pad_a (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cfg     (pa_cfg_reg),
      .alt_en  (pa_alt_en),
      .alt_val (pa_alt_val),
      .pin_i   (pa_pin_i),
      .pad     (pa_pad),
      .din     (pa_din),
      .toggle  (pa_tog)
   );

   ppfm_pad u_pad_b (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cfg     (pb_cfg_reg),
      .alt_en  (pb_alt_en),
      .alt_val (pb_alt_val),
      .pin_i   (pb_pin_i),
      .pad     (pb_pad),
      .din     (pb_din),
      .toggle  (pb_tog)
   );

   // ---------------- External reset pin as wake source
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_sync_reg     <= 3'b111;
         rst_pin_prev_reg <= 1'b1;
      end else begin
         rst_sync_reg <= {rst_sync_reg[1:0], external_reset_n};
         if (rst_sync_reg[1] == rst_sync_reg[2]) begin
            rst_pin_prev_reg <= rst_sync_reg[2];
         end
      end
   end
   assign rst_wake_w = ~rst_pin_prev_reg
                     & pa_cfg_reg.die[ppfm_pkg::PIN_RST_A];

   // ---------------- External interrupt edge detection
   assign e0_src_w = alt_reg[ppfm_pkg::ALT_EXT0_SEL]
                   ? pb_din[ppfm_pkg::PIN_EXT0_B]
                   : pa_din[ppfm_pkg::PIN_EXT0_A];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         e0_prev_reg <= 1'b0;
         e1_prev_reg <= 1'b0;
      end else begin
         e0_prev_reg <= e0_src_w;
         e1_prev_reg <= pa_din[ppfm_pkg::PIN_EXT1_A];
      end
   end

   assign e0_hit_w = edge_hit(e0_src_w, e0_prev_reg,
                     alt_reg[ppfm_pkg::ALT_EXT0_FALL]);
   assign e1_hit_w = edge_hit(pa_din[ppfm_pkg::PIN_EXT1_A], e1_prev_reg,
                     alt_reg[ppfm_pkg::ALT_EXT1_FALL]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_irq_line_zero <= 1'b0;
         ext_irq_line_one  <= 1'b0;
         wake_req          <= 1'b0;
      end else begin
         ext_irq_line_zero <= e0_hit_w;
         ext_irq_line_one  <= e1_hit_w;
         wake_req <= (|pa_tog) | (|pb_tog) | rst_wake_w;
      end
   end

   // ---------------- Sticky status and masked interrupt
   assign ev_w[ppfm_pkg::ST_EXT0] = e0_hit_w;
   assign ev_w[ppfm_pkg::ST_EXT1] = e1_hit_w;
   assign ev_w[ppfm_pkg::ST_WAKE] = (|pa_tog) | (|pb_tog) | rst_wake_w;

   // Set wins over read-clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_reg <= '0;
      end else if (rd_stat) begin
         stat_reg <= ev_w;
      end else begin
         stat_reg <= stat_reg | ev_w;
      end
   end

   assign irq = |(stat_reg & mask_reg);

   // ---------------- AXI4-Lite write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_have_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_do) begin
            w_have_reg <= 1'b0;
         end
      end
   end

   assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_reg & ~s_axi_bvalid;
   assign wr_do         = aw_have_reg & w_have_reg & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ppfm_pkg::RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         unique case (aw_addr_reg)
            ppfm_pkg::ADDR_PA_DATA, ppfm_pkg::ADDR_PA_DIR,
            ppfm_pkg::ADDR_PA_PH, ppfm_pkg::ADDR_PA_PL,
            ppfm_pkg::ADDR_PA_DIE, ppfm_pkg::ADDR_PB_DATA,
            ppfm_pkg::ADDR_PB_DIR, ppfm_pkg::ADDR_PB_PH,
            ppfm_pkg::ADDR_PB_PL, ppfm_pkg::ADDR_PB_DIE,
            ppfm_pkg::ADDR_ALT, ppfm_pkg::ADDR_IRQ_MASK: begin
               s_axi_bresp <= ppfm_pkg::RESP_OKAY;
            end
            default: begin
               s_axi_bresp <= ppfm_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pa_cfg_reg     <= '0;
         pb_cfg_reg     <= '0;
         pa_cfg_reg.die <= ppfm_pkg::DIE_RESET;
         pb_cfg_reg.die <= ppfm_pkg::DIE_RESET;
         alt_reg        <= '0;
         mask_reg       <= '0;
      end else if (wr_do) begin
         unique case (aw_addr_reg)
            ppfm_pkg::ADDR_PA_DATA:
               pa_cfg_reg.data <= lane0(pa_cfg_reg.data, w_data_reg,
                                        w_strb_reg);
            ppfm_pkg::ADDR_PA_DIR:
               pa_cfg_reg.dir <= lane0(pa_cfg_reg.dir, w_data_reg,
                                       w_strb_reg);
            ppfm_pkg::ADDR_PA_PH:
               pa_cfg_reg.pull_hi <= lane0(pa_cfg_reg.pull_hi, w_data_reg,
                                           w_strb_reg);
            ppfm_pkg::ADDR_PA_PL:
               pa_cfg_reg.pull_lo <= lane0(pa_cfg_reg.pull_lo, w_data_reg,
                                           w_strb_reg);
            ppfm_pkg::ADDR_PA_DIE:
               pa_cfg_reg.die <= lane0(pa_cfg_reg.die, w_data_reg,
                                       w_strb_reg);
            ppfm_pkg::ADDR_PB_DATA:
               pb_cfg_reg.data <= lane0(pb_cfg_reg.data, w_data_reg,
                                        w_strb_reg);
            ppfm_pkg::ADDR_PB_DIR:
               pb_cfg_reg.dir <= lane0(pb_cfg_reg.dir, w_data_reg,
                                       w_strb_reg);
            ppfm_pkg::ADDR_PB_PH:
               pb_cfg_reg.pull_hi <= lane0(pb_cfg_reg.pull_hi, w_data_reg,
                                           w_strb_reg);
            ppfm_pkg::ADDR_PB_PL:
               pb_cfg_reg.pull_lo <= lane0(pb_cfg_reg.pull_lo, w_data_reg,
                                           w_strb_reg);
            ppfm_pkg::ADDR_PB_DIE:
               pb_cfg_reg.die <= lane0(pb_cfg_reg.die, w_data_reg,
                                       w_strb_reg);
            ppfm_pkg::ADDR_ALT: begin
               if (w_strb_reg[0]) alt_reg[7:0] <= w_data_reg[7:0];
               if (w_strb_reg[1]) alt_reg[8] <= w_data_reg[8];
            end
            ppfm_pkg::ADDR_IRQ_MASK:
               if (w_strb_reg[0]) mask_reg <= w_data_reg[ppfm_pkg::ST_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // ---------------- AXI4-Lite read channel
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_do         = s_axi_arvalid & s_axi_arready;
   assign rd_stat       = rd_do & (s_axi_araddr == ppfm_pkg::ADDR_IRQ_STAT);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= ppfm_pkg::RESP_OKAY;
      end else if (rd_do) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= ppfm_pkg::RESP_OKAY;
         s_axi_rdata  <= '0;
         unique case (s_axi_araddr)
            ppfm_pkg::ADDR_PA_DATA:  s_axi_rdata[7:0] <= pa_cfg_reg.data;
            ppfm_pkg::ADDR_PA_DIR:   s_axi_rdata[7:0] <= pa_cfg_reg.dir;
            ppfm_pkg::ADDR_PA_PH:    s_axi_rdata[7:0] <= pa_cfg_reg.pull_hi;
            ppfm_pkg::ADDR_PA_PL:    s_axi_rdata[7:0] <= pa_cfg_reg.pull_lo;
            ppfm_pkg::ADDR_PA_DIE:   s_axi_rdata[7:0] <= pa_cfg_reg.die;
            ppfm_pkg::ADDR_PA_IN:    s_axi_rdata[7:0] <= pa_din;
            ppfm_pkg::ADDR_PB_DATA:  s_axi_rdata[7:0] <= pb_cfg_reg.data;
            ppfm_pkg::ADDR_PB_DIR:   s_axi_rdata[7:0] <= pb_cfg_reg.dir;
            ppfm_pkg::ADDR_PB_PH:    s_axi_rdata[7:0] <= pb_cfg_reg.pull_hi;
            ppfm_pkg::ADDR_PB_PL:    s_axi_rdata[7:0] <= pb_cfg_reg.pull_lo;
            ppfm_pkg::ADDR_PB_DIE:   s_axi_rdata[7:0] <= pb_cfg_reg.die;
            ppfm_pkg::ADDR_PB_IN:    s_axi_rdata[7:0] <= pb_din;
            ppfm_pkg::ADDR_ALT:
               s_axi_rdata[ppfm_pkg::ALT_W-1:0] <= alt_reg;
            ppfm_pkg::ADDR_IRQ_STAT:
               s_axi_rdata[ppfm_pkg::ST_W-1:0] <= stat_reg;
            ppfm_pkg::ADDR_IRQ_MASK:
               s_axi_rdata[ppfm_pkg::ST_W-1:0] <= mask_reg;
            default: s_axi_rresp <= ppfm_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- Assertions
   a_alt_pa3_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      alt_reg[ppfm_pkg::ALT_TB_PA3] |->
      (pa_pad.oe[3] && pa_pad.o[3] == timer_b_pwm_out))
      else $error("port A bit 3 not driven by timer B pwm");
   a_alt_pb7_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      alt_reg[ppfm_pkg::ALT_TC_PB7] |->
      (pb_pad.oe[7] && pb_pad.o[7] == timer_c_pwm_out))
      else $error("port B bit 7 not driven by timer C pwm");
   a_cmp_pa0_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      alt_reg[ppfm_pkg::ALT_CMP_PA0] |->
      pa_pad.o[0] == cmp_result_pin)
      else $error("port A bit 0 not driven by comparator");
   a_data_latch_out: assert property (@(posedge aclk) disable iff (!aresetn)
      (!pb_alt_en[0] && pb_cfg_reg.dir[0]) |->
      (pb_pad.oe[0] && pb_pad.o[0] == pb_cfg_reg.data[0]))
      else $error("port B bit 0 not following data latch");
   a_die_blocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (pa_din & ~pa_cfg_reg.die) == ppfm_pkg::ZERO8)
      else $error("disabled port A input not blocked");
   a_die_blocks_b: assert property (@(posedge aclk) disable iff (!aresetn)
      (pb_tog & ~pb_cfg_reg.die) == ppfm_pkg::ZERO8)
      else $error("disabled port B pin toggled");
   a_rst_wake_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      !pa_cfg_reg.die[ppfm_pkg::PIN_RST_A] |-> !rst_wake_w)
      else $error("reset pin wake not suppressed");
   // Rising edge on the line-one pin while rising edges are selected
   sequence s_e1_rise;
      (!pa_din[ppfm_pkg::PIN_EXT1_A] && !alt_reg[ppfm_pkg::ALT_EXT1_FALL])
      ##1 (pa_din[ppfm_pkg::PIN_EXT1_A]
           && !alt_reg[ppfm_pkg::ALT_EXT1_FALL]);
   endsequence
   a_ext1_rise_irq: assert property (@(posedge aclk) disable iff (!aresetn)
      s_e1_rise |=> ext_irq_line_one)
      else $error("line one missed rising edge");
   a_ext0_source: assert property (@(posedge aclk) disable iff (!aresetn)
      alt_reg[ppfm_pkg::ALT_EXT0_SEL] |->
      e0_src_w == pb_din[ppfm_pkg::PIN_EXT0_B])
      else $error("line zero source select wrong");
endmodule
